// *** verilog/osdcd_decoder.v ***
// osd command decoder: turns command bytes into device state and ram writes
// Function
// R1: byte 011110xx selects bank, low two bits into bank flags
// R2: master reset clears both bank flags
// R3: each opcode decoded only in its own bank; host selects bank first
// R4: bank 00, top bit 1: low seven bits into character register
// R5: bank 10, top bit 1: second-bank character code into character register
// R6: lower flag zero, top three bits zero: five bits into attribute register
// R7: font codes 80H-FCH: attribute bits 4..1 give foreground RGBI
// R8: font codes: attribute bit 0 switches blinking
// R9: carriage return FEH: bits 4..3 give next-line dot size
// R10: carriage return: bits 2..1 give row spacing 0/4/8/12 lines
// R11: carriage return: bit 0 set ends display
// R12: space FFH: bits 4..1 give background RGBI colour
// R13: space code bit 0 sets monitor output until space with bit cleared
// R14: address-high loads four bits into address bits 7..4
// R15: bank 00, nibble 0011 loads address bits 3..0
// R16: address-high is nibble 0010 in bank 00
// R17: bank 01, top two bits zero: six bits into clock divisor
// R18: bank 01, nibble 0100: scan mode from bits 3..2
// R19: bit 1 selects output polarity, active high default
// R20: bit 0 enables osd clock, disabled at reset
// R21: character code writes ram at address then increments address
// R22: ram word holds character in bits 12..5, attribute in 4..0
// R23: bank select always recognised; unmatched bytes ignored; decoder drops bank select in the cycle after a character
// R24: reset gives scan mode 00, polarity high, clock disabled
`timescale 1ns/10ps
`default_nettype none
`include "osdcd_defines.vh"
module osdcd_decoder #(
    parameter AW = `OSDCD_ADDR_W
) (
    input wire ref_clk,
    input wire resetn,
    input wire cmd_valid,
    input wire [7:0] cmd_byte,
    input wire [AW-1:0] disp_rd_addr,
    output reg [`OSDCD_WORD_W-1:0] disp_rd_data,
    output reg bank_flag_upper,
    output reg bank_flag_lower,
    output reg [7:0] char_code_holding_reg,
    output reg [4:0] attribute_holding_reg,
    output reg [AW-1:0] display_ram_address_reg,
    output reg [5:0] clock_divisor,
    output reg scan_mode_hi,
    output reg scan_mode_lo,
    output reg output_polarity_sel,
    output reg osd_clock_en,
    output reg active_char_monitor_out,
    output reg [3:0] fg_colour,
    output reg blink_on,
    output reg [1:0] next_line_dot_size,
    output reg [1:0] row_spacing,
    output reg end_of_display,
    output reg [3:0] bg_colour
);
    ////////////////////////////////////////////////////////////////////////
    // command decode
    localparam [3:0] OP_NONE = 4'h0;
    localparam [3:0] OP_BANK = 4'h1;
    localparam [3:0] OP_CHAR = 4'h2;
    localparam [3:0] OP_ATTR = 4'h3;
    localparam [3:0] OP_AHI = 4'h4;
    localparam [3:0] OP_ALO = 4'h5;
    localparam [3:0] OP_DIV = 4'h6;
    localparam [3:0] OP_CTRL = 4'h7;

    localparam ST_IDLE = 1'b0;
    localparam ST_WRITE = 1'b1;

    localparam [1:0] BANK_00 = 2'h0;
    localparam [1:0] BANK_01 = 2'h1;
    localparam [1:0] BANK_10 = 2'h2;
    localparam [1:0] MODE_RST = `OSDCD_MODE_RST;
    localparam [1:0] BANK_RST = `OSDCD_BANK_RST;
    localparam [AW-1:0] ADDR_STEP = {{(AW-1){1'b0}}, 1'b1};

    localparam [1:0] KIND_NONE = 2'h0;
    localparam [1:0] KIND_FONT = 2'h1;
    localparam [1:0] KIND_CR = 2'h2;
    localparam [1:0] KIND_SPACE = 2'h3;

    // first match wins; bank select is tried before any bank-qualified opcode
    function [3:0] decode_op;
        input [7:0] b;
        input [1:0] bank;
        begin
            if (b[7:2] == `OSDCD_BANK_SEL_OP)
                decode_op = OP_BANK;
            else if (b[7] && (bank == BANK_00 || bank == BANK_10))
                decode_op = OP_CHAR;
            else if (b[7:5] == 3'h0 && !bank[0])
                decode_op = OP_ATTR;
            else if (b[7:4] == `OSDCD_ADDR_HI_OP && bank == BANK_00)
                decode_op = OP_AHI;
            else if (b[7:4] == `OSDCD_ADDR_LO_OP && bank == BANK_00)
                decode_op = OP_ALO;
            else if (b[7:6] == 2'h0 && bank == BANK_01)
                decode_op = OP_DIV;
            else if (b[7:4] == `OSDCD_CTRL1_OP && bank == BANK_01)
                decode_op = OP_CTRL;
            else
                decode_op = OP_NONE;
        end
    endfunction

    // the code in the holding register decides what the attribute bits mean
    function [1:0] code_kind;
        input [7:0] code;
        begin
            if (code == `OSDCD_CODE_CR)
                code_kind = KIND_CR;
            else if (code == `OSDCD_CODE_SPACE)
                code_kind = KIND_SPACE;
            else if (code <= `OSDCD_CODE_FONT_MAX)
                code_kind = KIND_FONT;
            else
                code_kind = KIND_NONE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release
    // the pin may let go of reset at any moment; two flops align the release
    wire rst_sync_n;
    osdcd_sync #(.W(1)) u_rst_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .d(1'b1),
        .q(rst_sync_n)
    );

    wire [1:0] bank;
    wire [3:0] op;
    assign bank = {bank_flag_upper, bank_flag_lower};
    assign op = cmd_valid ? decode_op(cmd_byte, bank) : OP_NONE; // R3 R23

    reg state_r;
    reg state_nxt;
    wire [`OSDCD_WORD_W-1:0] ram_rd;
    wire ram_we;
    assign ram_we = (state_r == ST_WRITE);

    ////////////////////////////////////////////////////////////////////////
    // display ram
    osdcd_ram #(.AW(AW), .DW(`OSDCD_WORD_W)) u_ram (
        .ref_clk(ref_clk),
        .wr_en(ram_we),
        .wr_addr(display_ram_address_reg),
        .wr_data({char_code_holding_reg, attribute_holding_reg}), // R22
        .rd_addr(disp_rd_addr),
        .rd_data(ram_rd)
    );

    always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            disp_rd_data <= {`OSDCD_WORD_W{1'b0}};
        end else begin
            disp_rd_data <= ram_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command registers
    reg bank_flag_upper_nxt;
    reg bank_flag_lower_nxt;
    reg [7:0] char_code_holding_reg_nxt;
    reg [4:0] attribute_holding_reg_nxt;
    reg [AW-1:0] display_ram_address_reg_nxt;
    reg [5:0] clock_divisor_nxt;
    reg scan_mode_hi_nxt;
    reg scan_mode_lo_nxt;
    reg output_polarity_sel_nxt;
    reg osd_clock_en_nxt;

    always @* begin
        state_nxt = state_r;
        bank_flag_upper_nxt = bank_flag_upper;
        bank_flag_lower_nxt = bank_flag_lower;
        char_code_holding_reg_nxt = char_code_holding_reg;
        attribute_holding_reg_nxt = attribute_holding_reg;
        display_ram_address_reg_nxt = display_ram_address_reg;
        clock_divisor_nxt = clock_divisor;
        scan_mode_hi_nxt = scan_mode_hi;
        scan_mode_lo_nxt = scan_mode_lo;
        output_polarity_sel_nxt = output_polarity_sel;
        osd_clock_en_nxt = osd_clock_en;
        case (state_r)
            ST_IDLE: begin
                case (op)
                    OP_BANK: begin
                        bank_flag_upper_nxt = cmd_byte[1]; // R1
                        bank_flag_lower_nxt = cmd_byte[0]; // R1
                    end
                    OP_CHAR: begin
                        // code kept with top bit set so FE/FF decode stays exact
                        char_code_holding_reg_nxt = {1'b1, cmd_byte[6:0]}; // R4 R5
                        state_nxt = ST_WRITE;
                    end
                    OP_ATTR: begin
                        attribute_holding_reg_nxt = cmd_byte[4:0]; // R6
                    end
                    OP_AHI: begin
                        display_ram_address_reg_nxt[7:4] = cmd_byte[3:0]; // R14 R16
                    end
                    OP_ALO: begin
                        display_ram_address_reg_nxt[3:0] = cmd_byte[3:0]; // R15
                    end
                    OP_DIV: begin
                        clock_divisor_nxt = cmd_byte[5:0]; // R17
                    end
                    OP_CTRL: begin
                        scan_mode_hi_nxt = cmd_byte[3]; // R18
                        scan_mode_lo_nxt = cmd_byte[2]; // R18
                        output_polarity_sel_nxt = cmd_byte[1]; // R19
                        osd_clock_en_nxt = cmd_byte[0]; // R20
                    end
                    default: begin
                        // no opcode of the current bank matches: nothing changes
                    end
                endcase
            end
            ST_WRITE: begin
                // bytes arriving in this cycle are dropped; host spaces bytes
                display_ram_address_reg_nxt = display_ram_address_reg + ADDR_STEP; // R21
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bank_flag_upper <= BANK_RST[1]; // R2
            bank_flag_lower <= BANK_RST[0]; // R2
            char_code_holding_reg <= 8'h00;
            attribute_holding_reg <= 5'h00;
            display_ram_address_reg <= {AW{1'b0}};
            clock_divisor <= 6'h00;
            scan_mode_hi <= MODE_RST[1]; // R24
            scan_mode_lo <= MODE_RST[0]; // R24
            output_polarity_sel <= `OSDCD_POL_RST; // R24
            osd_clock_en <= `OSDCD_EN_RST; // R24
            state_r <= ST_IDLE;
        end else begin
            bank_flag_upper <= bank_flag_upper_nxt;
            bank_flag_lower <= bank_flag_lower_nxt;
            char_code_holding_reg <= char_code_holding_reg_nxt;
            attribute_holding_reg <= attribute_holding_reg_nxt;
            display_ram_address_reg <= display_ram_address_reg_nxt;
            clock_divisor <= clock_divisor_nxt;
            scan_mode_hi <= scan_mode_hi_nxt;
            scan_mode_lo <= scan_mode_lo_nxt;
            output_polarity_sel <= output_polarity_sel_nxt;
            osd_clock_en <= osd_clock_en_nxt;
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // attribute interpretation of the last written code
    reg [3:0] fg_colour_nxt;
    reg blink_on_nxt;
    reg [1:0] next_line_dot_size_nxt;
    reg [1:0] row_spacing_nxt;
    reg end_of_display_nxt;
    reg [3:0] bg_colour_nxt;
    reg active_char_monitor_out_nxt;

    always @* begin
        fg_colour_nxt = fg_colour;
        blink_on_nxt = blink_on;
        next_line_dot_size_nxt = next_line_dot_size;
        row_spacing_nxt = row_spacing;
        end_of_display_nxt = end_of_display;
        bg_colour_nxt = bg_colour;
        active_char_monitor_out_nxt = active_char_monitor_out;
        if (ram_we) begin
            case (code_kind(char_code_holding_reg))
                KIND_FONT: begin
                    fg_colour_nxt = attribute_holding_reg[4:1]; // R7
                    blink_on_nxt = attribute_holding_reg[0]; // R8
                end
                KIND_CR: begin
                    next_line_dot_size_nxt = attribute_holding_reg[4:3]; // R9
                    row_spacing_nxt = attribute_holding_reg[2:1]; // R10
                    end_of_display_nxt = attribute_holding_reg[0]; // R11
                end
                KIND_SPACE: begin
                    bg_colour_nxt = attribute_holding_reg[4:1]; // R12
                    active_char_monitor_out_nxt = attribute_holding_reg[0]; // R13
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fg_colour <= 4'h0;
            blink_on <= 1'b0;
            next_line_dot_size <= 2'h0;
            row_spacing <= 2'h0;
            end_of_display <= 1'b0;
            bg_colour <= 4'h0;
            active_char_monitor_out <= 1'b0;
        end else begin
            fg_colour <= fg_colour_nxt;
            blink_on <= blink_on_nxt;
            next_line_dot_size <= next_line_dot_size_nxt;
            row_spacing <= row_spacing_nxt;
            end_of_display <= end_of_display_nxt;
            bg_colour <= bg_colour_nxt;
            active_char_monitor_out <= active_char_monitor_out_nxt;
        end
    end
endmodule // osdcd_decoder
`default_nettype wire

// *** verilog/osdcd_defines.vh ***
// constants for the osd command decoder
`ifndef OSDCD_DEFINES_VH
`define OSDCD_DEFINES_VH
`define OSDCD_BANK_SEL_OP 6'h1E
`define OSDCD_ADDR_HI_OP 4'h2
`define OSDCD_ADDR_LO_OP 4'h3
`define OSDCD_CTRL1_OP 4'h4
`define OSDCD_CODE_CR 8'hFE
`define OSDCD_CODE_SPACE 8'hFF
`define OSDCD_CODE_FONT_MAX 8'hFC
`define OSDCD_BANK_RST 2'h0
`define OSDCD_MODE_RST 2'h0
`define OSDCD_POL_RST 1'h1
`define OSDCD_EN_RST 1'h0
`define OSDCD_ADDR_W 8
`define OSDCD_WORD_W 13
`define OSDCD_ATTR_W 5
`endif

// *** verilog/osdcd_ram.v ***
// display ram, 256 x 13, one write port and one read port
`timescale 1ns/10ps
`default_nettype none
`include "osdcd_defines.vh"
module osdcd_ram #(
    parameter AW = `OSDCD_ADDR_W,
    parameter DW = `OSDCD_WORD_W
) (
    input wire ref_clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // osdcd_ram
`default_nettype wire

// *** verilog/osdcd_sync.v ***
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/10ps
`default_nettype none
module osdcd_sync #(
    parameter W = 1
) (
    input wire ref_clk,
    input wire resetn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // osdcd_sync
`default_nettype wire

// *** sim/osdcd_assertions.sv ***
// port assertions for the osd command decoder
`timescale 1ns/10ps
`default_nettype none
module osdcd_assertions #(
    parameter AW = 8
) (
    input wire ref_clk,
    input wire resetn,
    input wire cmd_valid,
    input wire [7:0] cmd_byte,
    input wire bank_flag_upper,
    input wire bank_flag_lower,
    input wire [7:0] char_code_holding_reg,
    input wire [4:0] attribute_holding_reg,
    input wire [AW-1:0] display_ram_address_reg,
    input wire [5:0] clock_divisor,
    input wire scan_mode_hi,
    input wire scan_mode_lo,
    input wire output_polarity_sel,
    input wire osd_clock_en
);
    reg chr_r;
    wire acc = cmd_valid && !chr_r;
    wire [1:0] bk = {bank_flag_upper, bank_flag_lower};
    wire chr = acc && cmd_byte[7] && !bank_flag_lower;
    // the cycle after a character byte is dropped by the decoder
    always @(posedge ref_clk or negedge resetn)
        if (!resetn) chr_r <= 1'b0;
        else chr_r <= chr;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_bank_sel: assert property (acc && cmd_byte[7:2] == 6'h1E |=> bk == $past(cmd_byte[1:0]))
        else $error("bank flags not loaded");
    a_char_load: assert property (chr |=> char_code_holding_reg == {1'b1, $past(cmd_byte[6:0])})
        else $error("character register wrong");
    a_attr_load: assert property (acc && cmd_byte[7:5] == 3'h0 && !bank_flag_lower |=>
        attribute_holding_reg == $past(cmd_byte[4:0])) else $error("attribute register wrong");
    a_addr_hi: assert property (acc && bk == 2'h0 && cmd_byte[7:4] == 4'h2 |=>
        display_ram_address_reg[7:4] == $past(cmd_byte[3:0])) else $error("address high wrong");
    a_addr_lo: assert property (acc && bk == 2'h0 && cmd_byte[7:4] == 4'h3 |=>
        display_ram_address_reg[3:0] == $past(cmd_byte[3:0])) else $error("address low wrong");
    a_addr_incr: assert property (chr |-> ##2
        display_ram_address_reg == $past(display_ram_address_reg, 2) + 1'b1)
        else $error("address not incremented");
    a_div_load: assert property (acc && bk == 2'h1 && cmd_byte[7:6] == 2'h0 |=>
        clock_divisor == $past(cmd_byte[5:0])) else $error("divisor wrong");
    a_ctrl_load: assert property (acc && bk == 2'h1 && cmd_byte[7:4] == 4'h4 |=>
        {scan_mode_hi, scan_mode_lo, output_polarity_sel, osd_clock_en} == $past(cmd_byte[3:0]))
        else $error("control register wrong");
endmodule // osdcd_assertions
`default_nettype wire

// *** sim/osdcd_host_model.sv ***
// host model: sends command bytes to the decoder
`timescale 1ns/10ps
`default_nettype none
module osdcd_host_model (
    input wire ref_clk,
    output logic cmd_valid,
    output logic [7:0] cmd_byte
);
    initial begin
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
    end
    // one byte per call, so a character byte always has a quiet cycle after it
    task send(input logic [7:0] b);
        begin
            @(posedge ref_clk);
            cmd_valid <= 1'b1;
            cmd_byte <= b;
            @(posedge ref_clk);
            cmd_valid <= 1'b0;
            cmd_byte <= ~b;
        end
    endtask
endmodule // osdcd_host_model
`default_nettype wire

// *** sim/test_osd_command_decoder.sv ***
// testbench for the osd command decoder
`timescale 1ns/10ps
`default_nettype none
module test_osd_command_decoder;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] disp_rd_addr = 8'h00;
    wire cmd_valid, bank_flag_upper, bank_flag_lower, scan_mode_hi, scan_mode_lo;
    wire output_polarity_sel, osd_clock_en, active_char_monitor_out, blink_on, end_of_display;
    wire [7:0] cmd_byte, char_code_holding_reg, display_ram_address_reg;
    wire [12:0] disp_rd_data;
    wire [4:0] attribute_holding_reg;
    wire [5:0] clock_divisor;
    wire [3:0] fg_colour, bg_colour;
    wire [1:0] next_line_dot_size, row_spacing;
    int failures = 0;
    int total_checks = 0;
    osdcd_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte));
    osdcd_decoder uut (.ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .disp_rd_addr(disp_rd_addr), .disp_rd_data(disp_rd_data),
        .bank_flag_upper(bank_flag_upper), .bank_flag_lower(bank_flag_lower),
        .char_code_holding_reg(char_code_holding_reg),
        .attribute_holding_reg(attribute_holding_reg),
        .display_ram_address_reg(display_ram_address_reg), .clock_divisor(clock_divisor),
        .scan_mode_hi(scan_mode_hi), .scan_mode_lo(scan_mode_lo),
        .output_polarity_sel(output_polarity_sel), .osd_clock_en(osd_clock_en),
        .active_char_monitor_out(active_char_monitor_out), .fg_colour(fg_colour),
        .blink_on(blink_on), .next_line_dot_size(next_line_dot_size),
        .row_spacing(row_spacing), .end_of_display(end_of_display), .bg_colour(bg_colour));
    task chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
        begin
            total_checks++;
            if (seen !== exp) begin
                failures++;
                $display("MISMATCH %s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task w;
        begin
            repeat (2) @(posedge ref_clk);
            #1;
        end
    endtask
    task rd(input logic [7:0] a, input logic [12:0] exp);
        begin
            @(posedge ref_clk);
            disp_rd_addr <= a;
            repeat (3) @(posedge ref_clk);
            #1;
            chk("ram", disp_rd_data, exp);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d failures %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    initial forever #20 ref_clk = ~ref_clk;
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        #1;
        chk("bank", {bank_flag_upper, bank_flag_lower}, 2'h0);
        chk("ctrl", {scan_mode_hi, scan_mode_lo, output_polarity_sel, osd_clock_en}, 4'h2);
        // the decoder leaves reset two edges after the pin does
        repeat (2) @(posedge ref_clk);
        host.send(8'h78);
        host.send(8'h2F);
        host.send(8'h3E);
        w;
        chk("addr", display_ram_address_reg, 8'hFE);
        host.send(8'h1B);
        host.send(8'h85);
        w;
        chk("attr", attribute_holding_reg, 5'h1B);
        chk("char", char_code_holding_reg, 8'h85);
        chk("font", {fg_colour, blink_on}, 5'h1B);
        chk("addr", display_ram_address_reg, 8'hFF);
        host.send(8'h15);
        host.send(8'hFE);
        w;
        chk("cr", {next_line_dot_size, row_spacing, end_of_display}, 5'h15);
        chk("addr", display_ram_address_reg, 8'h00);
        host.send(8'h0B);
        host.send(8'hFF);
        w;
        chk("space", {bg_colour, active_char_monitor_out}, 5'h0B);
        host.send(8'h81);
        w;
        chk("acm", active_char_monitor_out, 1'b1);
        host.send(8'h0A);
        host.send(8'hFF);
        w;
        chk("acm", active_char_monitor_out, 1'b0);
        rd(8'hFE, {8'h85, 5'h1B});
        rd(8'hFF, {8'hFE, 5'h15});
        host.send(8'h7A);
        host.send(8'h90);
        host.send(8'h04);
        w;
        chk("bank", {bank_flag_upper, bank_flag_lower}, 2'h2);
        chk("char", char_code_holding_reg, 8'h90);
        chk("attr", attribute_holding_reg, 5'h04);
        host.send(8'h79);
        host.send(8'h3F);
        host.send(8'h85);
        host.send(8'h4E);
        w;
        chk("div", clock_divisor, 6'h3F);
        chk("char", char_code_holding_reg, 8'h90);
        chk("ctrl", {scan_mode_hi, scan_mode_lo, output_polarity_sel, osd_clock_en}, 4'hE);
        host.send(8'h05);
        host.send(8'h41);
        w;
        chk("div", clock_divisor, 6'h05);
        chk("attr", attribute_holding_reg, 5'h04);
        chk("ctrl", {scan_mode_hi, scan_mode_lo, output_polarity_sel, osd_clock_en}, 4'h1);
        host.send(8'h7B);
        host.send(8'h06);
        w;
        chk("bank", {bank_flag_upper, bank_flag_lower}, 2'h3);
        chk("div", clock_divisor, 6'h05);
        end_sim;
    end
endmodule // test_osd_command_decoder
bind osdcd_decoder osdcd_assertions #(.AW(AW)) chk_i (.ref_clk(ref_clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .bank_flag_upper(bank_flag_upper), .bank_flag_lower(bank_flag_lower),
    .char_code_holding_reg(char_code_holding_reg),
    .attribute_holding_reg(attribute_holding_reg),
    .display_ram_address_reg(display_ram_address_reg), .clock_divisor(clock_divisor),
    .scan_mode_hi(scan_mode_hi), .scan_mode_lo(scan_mode_lo),
    .output_polarity_sel(output_polarity_sel), .osd_clock_en(osd_clock_en));
`default_nettype wire
